// ===== rtl/hpa_consts.svh
// Offsets, field positions, reset values and timing counts of the amplifier control block.
`ifndef HPA_CONSTS_SVH
`define HPA_CONSTS_SVH

`define HPA_SLAVE_ADDR 7'h60
// Register pointers on the serial port.
`define HPA_REG_CTRL 8'h01
`define HPA_REG_VOL 8'h02
`define HPA_REG_TRI 8'h03
`define HPA_REG_ID 8'h04
// Control register fields.
`define HPA_BIT_STANDBY 0
`define HPA_BIT_FAULT 1
`define HPA_BIT_ENR 6
`define HPA_BIT_ENL 7
// Tri-state register fields.
`define HPA_BIT_TRIR 0
`define HPA_BIT_TRIL 1
// Reset values.
`define HPA_CTRL_RST 8'h01
`define HPA_VOL_RST 8'hC0
`define HPA_TRI_RST 8'h00
`define HPA_REV_VAL 4'h5
// APB byte addresses.
`define HPA_APB_CTRL 12'h000
`define HPA_APB_VOL 12'h004
`define HPA_APB_TRI 12'h008
`define HPA_APB_ID 12'h00C
`define HPA_APB_STAT 12'h010
// Timing.
`define HPA_CLK_MHZ 100
`define HPA_RETRY_MS 1000
`define HPA_RETRY_CYC (`HPA_RETRY_MS * 1000 * `HPA_CLK_MHZ)
`define HPA_GLITCH_NS 50
`define HPA_GLITCH_CYC ((`HPA_GLITCH_NS * `HPA_CLK_MHZ + 999) / 1000 + 1)

`endif

// ===== rtl/hpa_pkg.sv
// Types shared by the amplifier control block.
package hpa_pkg;
   typedef enum logic [2:0] {
      HPA_IDLE, HPA_ADDR, HPA_ACK, HPA_WDATA, HPA_RDATA, HPA_RACK
   } hpa_state_e;
   typedef enum logic [1:0] {
      HPA_RUN, HPA_TRIP
   } hpa_prot_e;
   typedef logic [7:0] hpa_byte_t;
endpackage

// ===== rtl/hpa_pin_if.sv
// Filtered serial pin levels and their decoded events.
`timescale 1ns/1ps
`default_nettype none
interface hpa_pin_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   modport filt (output scl, sda, scl_rise, scl_fall, start, stop);
   modport core (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface
`default_nettype wire

// ===== rtl/hpa_pin_filter.sv
// Synchroniser, glitch filter and edge decoder for the serial pins.
`timescale 1ns/1ps
`default_nettype none
`include "hpa_consts.svh"
module hpa_pin_filter #(
   parameter int FILT_CYC = `HPA_GLITCH_CYC
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Raw pins.
   input wire logic scl_in,
   input wire logic sda_in,
   // Filtered view.
   hpa_pin_if.filt pins
);
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic [3:0] scl_cnt_reg;
   logic [3:0] sda_cnt_reg;
   logic scl_reg;
   logic sda_reg;
   logic scl_d_reg;
   logic sda_d_reg;
   wire scl_diff = scl_sync_reg[1] != scl_reg;
   wire sda_diff = sda_sync_reg[1] != sda_reg;

   // A level must persist for longer than the longest spike to be taken.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_cnt_reg <= 4'h0;
         sda_cnt_reg <= 4'h0;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
         scl_cnt_reg <= scl_diff ? scl_cnt_reg + 4'h1 : 4'h0;
         sda_cnt_reg <= sda_diff ? sda_cnt_reg + 4'h1 : 4'h0;
         if (scl_diff && scl_cnt_reg == 4'(FILT_CYC - 1)) begin
            scl_reg <= scl_sync_reg[1];
         end
         if (sda_diff && sda_cnt_reg == 4'(FILT_CYC - 1)) begin
            sda_reg <= sda_sync_reg[1];
         end
         scl_d_reg <= scl_reg;
         sda_d_reg <= sda_reg;
      end
   end

   assign pins.scl = scl_reg;
   assign pins.sda = sda_reg;
   assign pins.scl_rise = scl_reg && !scl_d_reg;
   assign pins.scl_fall = !scl_reg && scl_d_reg;
   assign pins.start = scl_reg && scl_d_reg && !sda_reg && sda_d_reg;
   assign pins.stop = scl_reg && scl_d_reg && sda_reg && !sda_d_reg;
endmodule
`default_nettype wire

// ===== rtl/hpa_thermal.sv
// Thermal supervisor: timed disable and retry while overtemperature lasts.
`timescale 1ns/1ps
`default_nettype none
`include "hpa_consts.svh"
module hpa_thermal #(
   parameter int RETRY_CYC = `HPA_RETRY_CYC
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Supervision.
   input wire logic overtemp,
   input wire logic standby,
   output logic tripped,
   output logic fault_event
);
   import hpa_pkg::*;
   hpa_prot_e state_reg;
   logic [31:0] cnt_reg;
   wire sense = overtemp && !standby;
   wire done = cnt_reg == 32'(RETRY_CYC - 1);

   // The interval runs off pclk alone, with no tie to bus activity.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= HPA_RUN;
         cnt_reg <= 32'h0;
      end else begin
         case (state_reg)
            HPA_RUN: begin
               cnt_reg <= 32'h0;
               if (sense) begin
                  state_reg <= HPA_TRIP;
               end
            end
            HPA_TRIP: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (done) begin
                  state_reg <= HPA_RUN;
               end
            end
            default: state_reg <= HPA_RUN;
         endcase
      end
   end

   assign tripped = state_reg == HPA_TRIP;
   assign fault_event = state_reg == HPA_RUN && sense;

   a_trip_on_heat: assert property (
      @(posedge pclk) disable iff (!presetn)
      state_reg == HPA_RUN && sense |=> state_reg == HPA_TRIP)
      else $error("Overtemperature did not start a disable interval.");
   a_retry_after: assert property (
      @(posedge pclk) disable iff (!presetn)
      state_reg == HPA_TRIP && done |=> state_reg == HPA_RUN)
      else $error("Disable interval did not end on time.");
   a_no_standby_trip: assert property (
      @(posedge pclk) disable iff (!presetn)
      standby && state_reg == HPA_RUN |=> state_reg == HPA_RUN)
      else $error("Disable interval started while in standby.");
endmodule
`default_nettype wire

// ===== rtl/hpa_ctrl.sv
// Amplifier control: serial slave port, registers, protection and APB view.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hpa_consts.svh"
module hpa_ctrl #(
   parameter int RETRY_CYC = `HPA_RETRY_CYC,
   parameter int FILT_CYC = `HPA_GLITCH_CYC,
   // Supplier code and revision; the supplier value is arbitrary.
   parameter logic [1:0] SUPPLIER_ID = 2'h0,
   parameter logic [3:0] REVISION = `HPA_REV_VAL
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial pins.
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Analog supervision and power control.
   input wire logic overtemp,
   output logic amp_positive_rail,
   output logic amp_negative_rail,
   output logic left_amp_en,
   output logic right_amp_en,
   output logic [4:0] volume,
   output logic left_mute,
   output logic right_mute,
   output logic left_headphone_out_tristate,
   output logic right_headphone_out_tristate,
   output logic overtemp_fault_flag
);
   import hpa_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   hpa_pin_if pins ();
   hpa_pin_filter #(.FILT_CYC(FILT_CYC)) u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .pins(pins)
   );

   ////////////////////////////////////////////////////////////////////////////
   // The sensor level is asynchronous to pclk and passes two flip-flops.
   logic [1:0] heat_sync_reg;
   wire heat = heat_sync_reg[1];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         heat_sync_reg <= 2'h0;
      end else begin
         heat_sync_reg <= {heat_sync_reg[0], overtemp};
      end
   end

   logic tripped;
   logic fault_event;
   logic soft_standby;
   hpa_thermal #(.RETRY_CYC(RETRY_CYC)) u_overtemp_fault_flag (
      .pclk(pclk),
      .presetn(presetn),
      .overtemp(heat),
      .standby(soft_standby),
      .tripped(tripped),
      .fault_event(fault_event)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register read decode, shared by the serial port and the APB.
   hpa_byte_t ctrl_reg;
   hpa_byte_t vol_reg;
   hpa_byte_t tri_reg;
   logic fault_reg;

   function automatic hpa_byte_t reg_view(input hpa_byte_t ptr,
      input hpa_byte_t c, input hpa_byte_t v, input hpa_byte_t t,
      input logic f);
      case (ptr)
         `HPA_REG_CTRL: reg_view = {c[7:6], 4'h0, f, c[0]};
         `HPA_REG_VOL: reg_view = {v[7:1], 1'b0};
         `HPA_REG_TRI: reg_view = {6'h00, t[1:0]};
         `HPA_REG_ID: reg_view = {SUPPLIER_ID, 2'h0, REVISION};
         default: reg_view = 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Serial slave.
   hpa_state_e st_reg;
   hpa_byte_t shift_reg;
   hpa_byte_t ptr_reg;
   logic [3:0] bit_reg;
   logic rw_reg;
   logic have_ptr_reg;
   logic sda_oe_reg;
   logic rd_fault_reg;

   wire byte_done = bit_reg == 4'h7;
   wire addr_hit = shift_reg[7:1] == `HPA_SLAVE_ADDR;
   hpa_byte_t rd_byte;
   assign rd_byte = reg_view(ptr_reg, ctrl_reg, vol_reg, tri_reg, fault_reg);
   hpa_byte_t rx_byte;
   assign rx_byte = {shift_reg[6:0], pins.sda};
   logic i2c_wr;
   assign i2c_wr = st_reg == HPA_WDATA && pins.scl_rise && byte_done
      && have_ptr_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= HPA_IDLE;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         bit_reg <= 4'h0;
         rw_reg <= 1'b0;
         have_ptr_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         rd_fault_reg <= 1'b0;
      end else begin
         rd_fault_reg <= 1'b0;
         if (pins.start) begin
            st_reg <= HPA_ADDR;
            bit_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
         end else if (pins.stop) begin
            st_reg <= HPA_IDLE;
            sda_oe_reg <= 1'b0;
         end else begin
            case (st_reg)
               HPA_IDLE: sda_oe_reg <= 1'b0;
               HPA_ADDR, HPA_WDATA: begin
                  if (pins.scl_rise) begin
                     shift_reg <= rx_byte;
                     bit_reg <= bit_reg + 4'h1;
                  end
                  if (pins.scl_fall && bit_reg == 4'h8) begin
                     bit_reg <= 4'h0;
                     if (st_reg == HPA_ADDR && !addr_hit) begin
                        st_reg <= HPA_IDLE;
                     end else begin
                        sda_oe_reg <= 1'b1;
                        st_reg <= HPA_ACK;
                        if (st_reg == HPA_ADDR) begin
                           rw_reg <= shift_reg[0];
                           have_ptr_reg <= 1'b0;
                        end else if (!have_ptr_reg) begin
                           ptr_reg <= shift_reg;
                           have_ptr_reg <= 1'b1;
                        end else begin
                           ptr_reg <= ptr_reg + 8'h01;
                        end
                     end
                  end
               end
               HPA_ACK: begin
                  // Ack is held to the fall that ends the ninth clock.
                  if (pins.scl_fall) begin
                     if (rw_reg) begin
                        st_reg <= HPA_RDATA;
                        shift_reg <= rd_byte;
                        sda_oe_reg <= !rd_byte[7];
                        rd_fault_reg <= ptr_reg == `HPA_REG_CTRL;
                        bit_reg <= 4'h0;
                     end else begin
                        st_reg <= HPA_WDATA;
                        sda_oe_reg <= 1'b0;
                     end
                  end
               end
               HPA_RDATA: begin
                  if (pins.scl_fall) begin
                     bit_reg <= bit_reg + 4'h1;
                     if (bit_reg == 4'h7) begin
                        sda_oe_reg <= 1'b0;
                        st_reg <= HPA_RACK;
                        ptr_reg <= ptr_reg + 8'h01;
                     end else begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_oe_reg <= !shift_reg[6];
                     end
                  end
               end
               HPA_RACK: begin
                  if (pins.scl_rise) begin
                     // A released line on the ninth clock ends the read.
                     st_reg <= pins.sda ? HPA_IDLE : HPA_ACK;
                  end
               end
               default: st_reg <= HPA_IDLE;
            endcase
         end
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_reg;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave; zero wait states, unmapped addresses answer with pslverr.
   // Read data loads in the setup cycle so it stands at the access edge.
   wire apb_acc = psel && penable;
   wire apb_setup_rd = psel && !penable && !pwrite;
   wire apb_wr = apb_acc && pwrite;
   wire apb_rd = apb_acc && !pwrite;
   wire apb_hit = paddr == `HPA_APB_CTRL || paddr == `HPA_APB_VOL
      || paddr == `HPA_APB_TRI || paddr == `HPA_APB_ID
      || paddr == `HPA_APB_STAT;
   hpa_byte_t apb_view;
   assign apb_view = paddr == `HPA_APB_STAT
      ? {5'h00, tripped, soft_standby, heat}
      : reg_view(8'(paddr[11:2] + 10'h1), ctrl_reg, vol_reg, tri_reg,
         fault_reg);
   wire apb_fault_rd = apb_rd && paddr == `HPA_APB_CTRL;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (apb_setup_rd && apb_hit) begin
         prdata <= {24'h0, apb_view};
      end
   end
   assign pready = 1'b1;
   assign pslverr = apb_acc && !apb_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Registers; the serial port write wins over a same-cycle APB write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `HPA_CTRL_RST;
         vol_reg <= `HPA_VOL_RST;
         tri_reg <= `HPA_TRI_RST;
      end else if (i2c_wr) begin
         case (ptr_reg)
            `HPA_REG_CTRL: ctrl_reg <= rx_byte;
            `HPA_REG_VOL: vol_reg <= rx_byte;
            `HPA_REG_TRI: tri_reg <= rx_byte;
            default: ;
         endcase
      end else if (apb_wr) begin
         case (paddr)
            `HPA_APB_CTRL: ctrl_reg <= pwdata[7:0];
            `HPA_APB_VOL: vol_reg <= pwdata[7:0];
            `HPA_APB_TRI: tri_reg <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Set wins over the read that would clear; clearing needs the cause gone.
   wire flag_read = rd_fault_reg || apb_fault_rd;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_reg <= 1'b0;
      end else if (fault_event || tripped) begin
         fault_reg <= fault_reg | fault_event;
      end else if (flag_read && !heat) begin
         fault_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign soft_standby = ctrl_reg[`HPA_BIT_STANDBY];
   wire normal = !soft_standby && !tripped;
   assign amp_positive_rail = normal;
   assign amp_negative_rail = normal;
   assign left_amp_en = normal && ctrl_reg[`HPA_BIT_ENL];
   assign right_amp_en = normal && ctrl_reg[`HPA_BIT_ENR];
   assign volume = vol_reg[5:1];
   assign left_mute = vol_reg[7];
   assign right_mute = vol_reg[6];
   assign left_headphone_out_tristate = normal && tri_reg[`HPA_BIT_TRIL];
   assign right_headphone_out_tristate = normal && tri_reg[`HPA_BIT_TRIR];
   assign overtemp_fault_flag = fault_reg;

   ////////////////////////////////////////////////////////////////////////////
   a_fault_sticks: assert property (
      @(posedge pclk) disable iff (!presetn)
      fault_reg && !flag_read |=> fault_reg)
      else $error("Fault flag dropped without a read.");
   a_standby_rails: assert property (
      @(posedge pclk) disable iff (!presetn)
      soft_standby |-> !amp_positive_rail && !amp_negative_rail)
      else $error("Rails powered during standby.");
   a_tristate_normal: assert property (
      @(posedge pclk) disable iff (!presetn)
      left_headphone_out_tristate |-> !soft_standby && !tripped)
      else $error("Tristate outside normal operation.");
   a_tristate_right: assert property (
      @(posedge pclk) disable iff (!presetn)
      right_headphone_out_tristate |-> !soft_standby && !tripped)
      else $error("Right tristate outside normal operation.");
   a_ack_begin: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_reg == HPA_WDATA && pins.scl_fall && bit_reg == 4'h8
      && !pins.start && !pins.stop |=> sda_oe_reg && st_reg == HPA_ACK)
      else $error("Received byte was not acknowledged.");
   a_ack_held: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_reg == HPA_ACK && sda_oe_reg && !pins.scl_fall && !pins.start
      && !pins.stop |=> sda_oe_reg)
      else $error("Ack released before the ninth clock ended.");
   a_drive_on_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      $changed(sda_oe_reg) && !$past(pins.start) && !$past(pins.stop)
      |-> !$past(pins.scl))
      else $error("Data line moved while clock high.");
   a_bad_addr: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_reg == HPA_ADDR && pins.scl_fall && bit_reg == 4'h8 && !addr_hit
      && !pins.start && !pins.stop |=> st_reg == HPA_IDLE && !sda_oe_reg)
      else $error("Foreign address was acknowledged.");
   a_ptr_step: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_reg == HPA_RDATA && pins.scl_fall && bit_reg == 4'h7 && !pins.start
      && !pins.stop |=> ptr_reg == $past(ptr_reg) + 8'h01)
      else $error("Pointer did not advance after a read byte.");
   a_fault_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      fault_event |=> fault_reg)
      else $error("Fault event not recorded.");
endmodule
`default_nettype wire

// ===== test/hpa_i2c_host.sv
// Behavioural serial bus master that drives the amplifier's serial port.
`timescale 1ns/1ps
`default_nettype none
module hpa_i2c_host #(
   parameter int HALF = 8
) (
   // Clock and observed data line level.
   input wire logic pclk,
   input wire logic sda,
   // Driven lines; sda_low pulls the open-drain data line low.
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // The low phase is twice the high phase: the port sees the pins about
   // one high phase late and needs that time to release its acknowledge.
   task automatic bit_out(input logic b, output logic s);
      tick(HALF);
      sda_low <= !b;
      tick(HALF);
      scl <= 1'b1;
      tick(HALF);
      s = sda;
      scl <= 1'b0;
   endtask

   task automatic start();
      sda_low <= 1'b1;
      tick(HALF);
      scl <= 1'b0;
   endtask

   task automatic rstart();
      tick(HALF);
      sda_low <= 1'b0;
      tick(HALF);
      scl <= 1'b1;
      tick(HALF);
      sda_low <= 1'b1;
      tick(HALF);
      scl <= 1'b0;
   endtask

   task automatic stop();
      tick(HALF);
      sda_low <= 1'b1;
      tick(HALF);
      scl <= 1'b1;
      tick(HALF);
      sda_low <= 1'b0;
      tick(4 * HALF);
   endtask

   // A clock spike short enough that the port must not count it.
   task automatic spike();
      tick(HALF);
      scl <= 1'b1;
      tick(4);
      scl <= 1'b0;
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_out(d[i], s);
      end
      bit_out(1'b1, s);
      ack = !s;
   endtask

   task automatic rbyte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_out(1'b1, s);
         d[i] = s;
      end
      bit_out(last, s);
   endtask
endmodule
`default_nettype wire

// ===== test/test_amp_i2c_control_protection.sv
// Self-checking bench for the amplifier control block.
`timescale 1ns/1ps
`default_nettype none
`include "hpa_consts.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
   err_total++; $display("mismatch at %0t: got %h expected %h", \
   $time, got, exp); end end
module test_amp_i2c_control_protection;
   import hpa_pkg::*;
   localparam int RETRY = 1000;
   logic pclk, presetn, psel, penable, pwrite, overtemp, ack, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic pready, pslverr, sda_out, sda_oe, scl_m, sda_low_m, rail_q;
   logic pos_rail, neg_rail, l_en, r_en, l_mute, r_mute, l_tri, r_tri, flag;
   logic [4:0] volume;
   wire sda_line;
   int err_total, compares, rises, r0;
   hpa_byte_t c, v, x, b;
   hpa_byte_t wv [3];
   logic [11:0] ra [3] = '{`HPA_APB_CTRL, `HPA_APB_VOL, `HPA_APB_TRI};

   assign sda_line = !(sda_low_m | (sda_oe & !sda_out));

   hpa_i2c_host #(.HALF(8)) host (.pclk(pclk), .sda(sda_line),
      .scl(scl_m), .sda_low(sda_low_m));

   hpa_ctrl #(.RETRY_CYC(RETRY)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scl_in(scl_m), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .overtemp(overtemp),
      .amp_positive_rail(pos_rail), .amp_negative_rail(neg_rail),
      .left_amp_en(l_en), .right_amp_en(r_en), .volume(volume),
      .left_mute(l_mute), .right_mute(r_mute),
      .left_headphone_out_tristate(l_tri),
      .right_headphone_out_tristate(r_tri),
      .overtemp_fault_flag(flag));

   function automatic hpa_byte_t exp_reg(input int i, input hpa_byte_t w);
      hpa_byte_t m [3];
      m = '{8'hC1, 8'hFE, 8'h03};
      return w & m[i];
   endfunction

   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] rd, output logic er);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      er = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic end_of_test();
      $display("counts: %0d compares, %0d mismatches", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      rail_q <= pos_rail;
      if (pos_rail === 1'b1 && rail_q === 1'b0) begin
         rises <= rises + 1;
      end
   end

   initial begin
      repeat (30000) @(posedge pclk);
      err_total++;
      $display("mismatch at %0t: run did not finish", $time);
      end_of_test();
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, overtemp} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      r0 = $urandom(21136);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      wv = '{`HPA_CTRL_RST, `HPA_VOL_RST, `HPA_TRI_RST};
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, ra[i], 32'h0, r, e);
         `CHK(r, {24'h0, wv[i]})
      end
      apb(1'b0, `HPA_APB_ID, 32'h0, r, e);
      `CHK(r, {24'h0, 2'h0, 2'h0, `HPA_REV_VAL})
      `CHK(pos_rail, 1'b0)
      apb(1'b1, 12'h020, 32'hFF, r, e);
      `CHK(e, 1'b1)
      $display("test reset values done");

      c = 8'($urandom) & 8'hC2;
      v = 8'($urandom);
      wv = '{c, v, 8'h03};
      host.start();
      host.spike();
      host.wbyte({`HPA_SLAVE_ADDR, 1'b0}, ack);
      `CHK(ack, 1'b1)
      host.wbyte(`HPA_REG_CTRL, ack);
      `CHK(ack, 1'b1)
      for (int i = 0; i < 3; i++) begin
         host.wbyte(wv[i], ack);
         `CHK(ack, 1'b1)
      end
      host.stop();
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, ra[i], 32'h0, r, e);
         `CHK(r[7:0], exp_reg(i, wv[i]))
      end
      `CHK({pos_rail, neg_rail, l_en, r_en}, {2'b11, c[7], c[6]})
      `CHK({l_mute, r_mute, volume}, v[7:1])
      `CHK({l_tri, r_tri}, 2'b11)
      x = {`HPA_SLAVE_ADDR ^ 7'(($urandom % 127) + 1), 1'b0};
      host.start();
      host.wbyte(x, ack);
      `CHK(ack, 1'b0)
      host.stop();
      $display("test serial write done");

      overtemp <= 1'b1;
      repeat (20) @(posedge pclk);
      `CHK({pos_rail, neg_rail, flag}, 3'b001)
      `CHK({l_tri, r_tri}, 2'b00)
      apb(1'b0, `HPA_APB_CTRL, 32'h0, r, e);
      `CHK(r[1], 1'b1)
      r0 = rises;
      repeat (2500) @(posedge pclk);
      `CHK(rises - r0, 2)
      overtemp <= 1'b0;
      repeat (1100) @(posedge pclk);
      `CHK({pos_rail, flag, l_tri}, 3'b111)
      apb(1'b0, `HPA_APB_CTRL, 32'h0, r, e);
      `CHK(r[1], 1'b1)
      `CHK(flag, 1'b0)
      $display("test thermal retry done");

      apb(1'b1, `HPA_APB_CTRL, 32'h01, r, e);
      `CHK({pos_rail, neg_rail, l_tri, r_tri}, 4'h0)
      overtemp <= 1'b1;
      repeat (1200) @(posedge pclk);
      `CHK(flag, 1'b0)
      overtemp <= 1'b0;
      wv = '{8'h01, exp_reg(1, v), 8'h03};
      host.start();
      host.wbyte({`HPA_SLAVE_ADDR, 1'b0}, ack);
      host.wbyte(`HPA_REG_CTRL, ack);
      host.rstart();
      host.wbyte({`HPA_SLAVE_ADDR, 1'b1}, ack);
      `CHK(ack, 1'b1)
      for (int i = 0; i < 3; i++) begin
         host.rbyte(i == 2, b);
         `CHK(b, wv[i])
      end
      host.stop();
      $display("test standby done");
      end_of_test();
   end
endmodule
`default_nettype wire
